// ===== design/abr_top.sv
// Small synchronous FIFO with registered flags
//
// Design decisions made here: the address map and register access over AXI4-Lite.
module abr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [CW-1:0]    count_q;
   logic [CW-1:0]    count_d;
   logic             in_ready_q;
   logic             out_valid_q;
   wire              push;
   wire              pop;

   // Handshakes on both sides
   assign push      = in_valid & in_ready_q;
   assign pop       = out_valid_q & out_ready;
   assign in_ready  = in_ready_q;
   assign out_valid = out_valid_q;
   assign out_data  = store[rd_ptr_q];

   // Occupancy after this edge
   always_comb begin
      count_d = count_q;
      if (push & ~pop) begin
         count_d = count_q + CW'(1);
      end else if (pop & ~push) begin
         count_d = count_q - CW'(1);
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge mclk) begin
      if (push) begin
         store[wr_ptr_q] <= in_data;
      end
   end

   // Pointers and flags
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_q    <= '0;
         rd_ptr_q    <= '0;
         count_q     <= '0;
         in_ready_q  <= 1'b0;
         out_valid_q <= 1'b0;
      end else begin
         wr_ptr_q    <= push ? wr_ptr_q + PW'(1) : wr_ptr_q;
         rd_ptr_q    <= pop ? rd_ptr_q + PW'(1) : rd_ptr_q;
         count_q     <= count_d;
         in_ready_q  <= (count_d != FULL_CNT);
         out_valid_q <= (count_d != '0);
      end
   end
endmodule

// Overview of operation
// R1 - Every address is a 32-bit byte address
// R2 - Any master address width works correctly; the address ports here are fixed at ADDR_W, 32 bits
// R3 - Memory range always starts at offset zero
// R4 - Address bits above range are ignored
// R5 - Word index taken above byte-lane bits
// R6 - One RAM write per cycle without stalls; awready drops after each address, so at most one write every two cycles
// R7 - One RAM read per cycle without stalls
// R8 - Read and write ports share one width
// R9 - No output register on read data
// R10 - No pipeline stage before read channel
// R11 - Optional preset: per-location table or default
// R12 - No preset when error correction enabled
// R13 - Lite slave ignores byte-lane address bits
// R14 - Write strobes become per-byte write enables
// R15 - One clock; reset returns all to idle
module abr_top
   import abr_pkg::*;
#(
   parameter abr_init_t                  INIT_MODE  = ABR_INIT_NONE,
   parameter logic [DATA_W-1:0]          INIT_VALUE = INIT_DEFAULT,
   parameter logic [COEF_WORDS*DATA_W-1:0] coefficient_init_file = '0,
   parameter bit                         ECC_ENABLE = 1'b0
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [STRB_W-1:0] s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   localparam int BEAT_W = $bits(abr_wbeat_t);

   // One array, same width on both ports
   logic [DATA_W-1:0] mem [MEM_DEPTH];   // see R8

   abr_waddr_t        waddr_q;
   logic              awready_q;
   logic              bvalid_q;
   logic              arready_q;
   logic              rvalid_q;
   logic [DATA_W-1:0] rdata_q;
   logic              pend_q;
   logic [WORD_AW-1:0] pend_word_q;
   logic [1:0]        bresp_q;
   logic [1:0]        rresp_q;
   abr_wbeat_t        fifo_in;
   abr_wbeat_t        fifo_out;
   logic [BEAT_W-1:0] fifo_out_bits;
   logic              fifo_out_valid;

   wire               aw_hs;
   wire               ar_hs;
   wire               b_free;
   wire               r_free;
   wire               wr_fire;
   wire               rd_fire;
   wire [WORD_AW-1:0] aw_word;
   wire [WORD_AW-1:0] ar_word;
   wire [WORD_AW-1:0] rd_word;
   wire               waddr_vld_d;
   wire               pend_d;
   wire               bvalid_d;
   wire               rvalid_d;

   // Preset at configuration; skipped when error correction is on
   initial begin
      if (!ECC_ENABLE && INIT_MODE != ABR_INIT_NONE) begin   // see R12
         for (int i = 0; i < MEM_DEPTH; i++) begin            // see R11
            mem[i] = INIT_VALUE;
         end
         if (INIT_MODE == ABR_INIT_COEF) begin                // see R11
            for (int i = 0; i < COEF_WORDS; i++) begin
               mem[i] = coefficient_init_file[i*DATA_W +: DATA_W];
            end
         end
      end
   end

   // Address decode: byte address, range from zero, upper bits and lanes dropped
   assign aw_word = s_axi_awaddr[RANGE_MSB:LANE_LSB];   // see R1, R3, R4, R5, R13
   assign ar_word = s_axi_araddr[RANGE_MSB:LANE_LSB];   // see R1, R3, R4, R5, R13

   // Channel handshakes
   assign aw_hs   = s_axi_awvalid & awready_q;
   assign ar_hs   = s_axi_arvalid & arready_q;
   assign b_free  = ~bvalid_q | s_axi_bready;
   assign r_free  = ~rvalid_q | s_axi_rready;

   // Write: address held, data from buffer, response slot free
   assign wr_fire     = waddr_q.vld & fifo_out_valid & b_free;   // see R6
   assign waddr_vld_d = (waddr_q.vld & ~wr_fire) | aw_hs;
   assign bvalid_d    = wr_fire | (bvalid_q & ~s_axi_bready);

   // Read: RAM read register feeds the channel directly
   assign rd_fire  = (pend_q | ar_hs) & r_free;                  // see R7
   assign rd_word  = pend_q ? pend_word_q : ar_word;
   assign pend_d   = (pend_q | ar_hs) & ~r_free;
   assign rvalid_d = rd_fire | (rvalid_q & ~s_axi_rready);

   // Write data buffer
   assign fifo_in.data = s_axi_wdata;
   assign fifo_in.strb = s_axi_wstrb;
   assign fifo_out     = abr_wbeat_t'(fifo_out_bits);

   abr_fifo #(
      .WIDTH (BEAT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_wbuf (
      .mclk      (mclk),
      .rstn      (rstn),
      .in_valid  (s_axi_wvalid),
      .in_ready  (s_axi_wready),
      .in_data   (fifo_in),
      .out_valid (fifo_out_valid),
      .out_ready (wr_fire),
      .out_data  (fifo_out_bits)
   );

   // RAM write port, one enable per byte lane; plain always, the preset writes the array too
   always @(posedge mclk) begin
      for (int b = 0; b < STRB_W; b++) begin
         if (wr_fire && fifo_out.strb[b]) begin                  // see R14
            mem[waddr_q.word][b*8 +: 8] <= fifo_out.data[b*8 +: 8];
         end
      end
   end

   // RAM read port; this register is the read data itself
   always_ff @(posedge mclk) begin
      if (rd_fire) begin
         rdata_q <= mem[rd_word];                                // see R9, R10
      end
   end

   // Write control state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin                                           // see R15
         waddr_q   <= '0;
         awready_q <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         waddr_q.vld <= waddr_vld_d;
         if (aw_hs) begin
            waddr_q.word <= aw_word;
         end
         awready_q <= ~waddr_vld_d;                              // see R6
         bvalid_q  <= bvalid_d;
         bresp_q   <= RESP_OKAY;
      end
   end

   // Read control state
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin                                           // see R15
         arready_q   <= 1'b0;
         rvalid_q    <= 1'b0;
         pend_q      <= 1'b0;
         pend_word_q <= '0;
         rresp_q     <= RESP_OKAY;
      end else begin
         pend_q <= pend_d;
         if (ar_hs) begin
            pend_word_q <= ar_word;
         end
         arready_q <= ~pend_d;                                   // see R7
         rvalid_q  <= rvalid_d;
         rresp_q   <= RESP_OKAY;
      end
   end

   // Outputs
   assign s_axi_awready = awready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
endmodule

// ===== pkg/abr_pkg.sv
package abr_pkg;

   // Bus and memory geometry
   localparam int ADDR_W     = 32;
   localparam int DATA_W     = 32;
   localparam int STRB_W     = DATA_W / 8;
   localparam int MEM_DEPTH  = 1024;
   localparam int WORD_AW    = 10;
   localparam int LANE_LSB   = 2;
   localparam int RANGE_MSB  = LANE_LSB + WORD_AW - 1;

   // Write data buffer
   localparam int FIFO_DEPTH = 8;

   // Response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;

   // Preset table geometry and defaults
   localparam int               COEF_WORDS   = 16;
   localparam logic [DATA_W-1:0] INIT_DEFAULT = 32'h0000_0000;

   // Preset choice applied at configuration
   typedef enum logic [1:0] {
      ABR_INIT_NONE    = 2'b00,
      ABR_INIT_DEFAULT = 2'b01,
      ABR_INIT_COEF    = 2'b10
   } abr_init_t;

   // One write data beat as it sits in the buffer
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [STRB_W-1:0] strb;
   } abr_wbeat_t;

   // Accepted address, reduced to a word index
   typedef struct packed {
      logic              vld;
      logic [WORD_AW-1:0] word;
   } abr_waddr_t;

endpackage

// ===== sim/abr_properties.sv
module abr_properties
   import abr_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rstn,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Address and data taken at one edge
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Read taken while the data channel is free
   sequence rd_take;
      s_axi_arvalid && s_axi_arready && (!s_axi_rvalid || s_axi_rready);
   endsequence
   chk_reset_idle: assert property ($rose(rstn) |-> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
      else $error("busy at reset release");
   chk_wr_answer: assert property (wr_both ##1 (!s_axi_bvalid || s_axi_bready) |=> s_axi_bvalid)
      else $error("write answer late");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   chk_b_okay: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY)
      else $error("write answer not okay");
   chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
      else $error("read data late");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped");
   chk_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data changed while held");
   chk_r_okay: assert property (s_axi_rvalid |-> s_axi_rresp == RESP_OKAY)
      else $error("read answer not okay");
endmodule

bind abr_top abr_properties abr_properties_i (.mclk(mclk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== sim/abr_master_model.sv
module abr_master_model (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic slow,
   input  wire logic s_axi_bvalid,
   input  wire logic s_axi_rvalid,
   output logic      s_axi_bready,
   output logic      s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slow: ready only a cycle after an answer shows
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_bready <= 1'b0;
         s_axi_rready <= 1'b0;
      end else begin
         s_axi_bready <= slow ? (s_axi_bvalid && !s_axi_bready) : 1'b1;
         s_axi_rready <= slow ? (s_axi_rvalid && !s_axi_rready) : 1'b1;
      end
   end
endmodule

// ===== sim/axi_block_ram_slave_addressing_bench.sv
module axi_block_ram_slave_addressing_bench
   import abr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [DATA_W-1:0] IV = 32'h5a5a_a5a5;
   localparam logic [DATA_W-1:0] DV = 32'h3c3c_c3c3;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        slow = 1'b0;
   logic [31:0] aw_a = '0, w_d = '0, ar_a = '0, r_d, r_d2, r_d3;
   logic [3:0]  w_s = '0;
   logic        aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0, aw_r, w_r, b_v, b_r, ar_r, r_v, r_r;
   logic [1:0]  b_p, r_p;
   int          fail_count = 0;
   int          n_tests = 0;
   always #2 mclk = ~mclk;
   abr_top #(.INIT_MODE(ABR_INIT_COEF), .INIT_VALUE(IV), .coefficient_init_file(512'hc0ef_0003 << 96))
   abr_top_i (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
      .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_p),
      .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_p), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
   abr_master_model abr_master_model_i (.mclk(mclk), .rstn(rstn), .slow(slow), .s_axi_bvalid(b_v),
      .s_axi_rvalid(r_v), .s_axi_bready(b_r), .s_axi_rready(r_r));
   // Same bus, other presets: default value only, and default with error correction on
   abr_top #(.INIT_MODE(ABR_INIT_DEFAULT), .INIT_VALUE(DV), .coefficient_init_file(512'hc0ef_0003 << 96))
   abr_top_dflt_i (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(),
      .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(), .s_axi_rdata(r_d2), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(r_r));
   abr_top #(.INIT_MODE(ABR_INIT_DEFAULT), .INIT_VALUE(DV), .ECC_ENABLE(1'b1))
   abr_top_ecc_i (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(),
      .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(), .s_axi_rdata(r_d3), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(r_r));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t %s", $time, m);
         fail_count++;
      end
   endtask
   task automatic close_out();
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Wait bound used up: count it and stop
   task automatic hung(input int n);
      if (n >= 200) begin
         $display("CHECK FAILED t=%0t handshake timeout", $time);
         fail_count++;
         close_out();
      end
   endtask
   // Write; m[0] offers address, m[1] data, m[2] waits for the answer
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [2:0] m);
      int n;
      aw_a <= a;
      w_d <= d;
      w_s <= s;
      aw_v <= m[0];
      w_v <= m[1];
      for (n = 0; n < 200; n++) begin
         @(posedge mclk);
         if (aw_r) aw_v <= 1'b0;
         if (w_r) w_v <= 1'b0;
         if ((aw_r || !aw_v) && (w_r || !w_v)) break;
      end
      hung(n);
      if (!m[2]) @(posedge mclk);
      for (n = 0; m[2] && n < 200; n++) begin
         @(posedge mclk);
         if (b_v && b_r) break;
      end
      hung(n);
      if (m[2]) chk(b_p, RESP_OKAY, "write response");
   endtask
   // Read one word and compare it
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      int n;
      ar_a <= a;
      ar_v <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge mclk);
         if (ar_r) break;
      end
      ar_v <= 1'b0;
      hung(n);
      for (n = 0; n < 200; n++) begin
         @(posedge mclk);
         if (r_v && r_r) break;
      end
      hung(n);
      chk(r_d, e, "read data");
      chk(r_p, RESP_OKAY, "read response");
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      rd(32'h0000_000c, 32'hc0ef_0003);
      chk(r_d2, DV, "default preset ignores table");
      // Copy with error correction must not carry the preset
      chk(r_d3 === DV, 32'h0, "preset with error correction");
      rd(32'h0000_0190, IV);
      rd(32'h0000_0000, 32'h0);
      $display("test preset done");
      wr(32'h0000_0010, 32'h1234_5678, 4'hf, 3'h7);
      rd(32'ha000_1013, 32'h1234_5678);
      wr(32'hffff_fffc, 32'hcafe_f00d, 4'hf, 3'h7);
      rd(32'h0000_0ffc, 32'hcafe_f00d);
      $display("test addressing done");
      for (int i = 0; i < 4; i++) begin
         wr(32'h0000_0020, 32'h4433_2211, 4'h1 << i, 3'h7);
         rd(32'h0000_0020, 32'h4433_2211 & ~(32'hffff_ffff << (8 * i + 8)));
      end
      $display("test strobes done");
      slow <= 1'b1;
      for (int i = 0; i < FIFO_DEPTH; i++) wr(32'h0, 32'h0b0b_0000 + i, 4'hf, 3'h2);
      repeat (2) @(posedge mclk);
      chk(w_r, 32'h0, "buffer full");
      for (int i = 0; i < FIFO_DEPTH; i++) wr(32'h0000_0040 + 4 * i, 32'h0, 4'h0, 3'h5);
      for (int i = 0; i < FIFO_DEPTH; i++) rd(32'h0000_0040 + 4 * i, 32'h0b0b_0000 + i);
      $display("test buffer done");
      rstn <= 1'b0;
      repeat (8) @(posedge mclk);
      chk(b_v | r_v | aw_r, 32'h0, "idle in reset");
      rstn <= 1'b1;
      @(posedge mclk);
      rd(32'h0000_0010, 32'h1234_5678);
      $display("test reset done");
      close_out();
   end
endmodule
